/* File: core/isae_pkg.sv */
/*
 * constants, register map and field layout of the image statistics engine.
 * assumes a 32-bit avalon-mm slave with byte addresses and word access.
 */
package isae_pkg;

	// ------------------------------------------------------------
	// widths and limits
	// ------------------------------------------------------------
	localparam int PIX_W     = 14;
	localparam int DATA_W    = 32;
	localparam int ADDR_W    = 17;
	localparam int WADDR_W   = ADDR_W - 2;
	localparam int COORD_W   = 16;
	localparam int ROW_W     = 8;
	localparam int COL_W     = 6;
	localparam int MAX_COLS  = 36;
	localparam int MAX_ROWS  = 128;
	localparam int MEM_N     = MAX_COLS * MAX_ROWS;
	localparam int IDX_W     = 13;
	localparam int FILT_N    = 2;
	localparam int COEF_PER  = 11;
	localparam int COEF_N    = FILT_N * COEF_PER;
	localparam int COEF_W    = 12;
	localparam int COEF_FRAC = 6;
	localparam int ACC_W     = 24;
	localparam int FV_W      = 24;
	localparam int CFG_N     = 13;
	localparam int CFG_IW    = 4;
	localparam int COEF_IW   = 5;

	// ------------------------------------------------------------
	// configuration word indices (byte offset is four times)
	// ------------------------------------------------------------
	localparam int CFG_CTRL     = 0;
	localparam int CFG_STATUS   = 1;
	localparam int CFG_AF_HST   = 2;
	localparam int CFG_AF_VST   = 3;
	localparam int CFG_AF_SIZE  = 4;
	localparam int CFG_AF_COUNT = 5;
	localparam int CFG_AF_LINC  = 6;
	localparam int CFG_EB_START = 7;
	localparam int CFG_EB_SIZE  = 8;
	localparam int CFG_EB_COUNT = 9;
	localparam int CFG_EB_SAMP  = 10;
	localparam int CFG_EB_SAT   = 11;
	localparam int CFG_EB_BLACK = 12;

	localparam logic [WADDR_W-1:0] COEF_WBASE = 15'h0010;
	localparam logic [WADDR_W-1:0] AF_WBASE   = 15'h2000;
	localparam logic [WADDR_W-1:0] EB_WBASE   = 15'h4000;
	localparam logic [WADDR_W-1:0] BLK_WBASE  = 15'h6000;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int CTRL_SRC       = 0;
	localparam int CTRL_AF_EN     = 1;
	localparam int CTRL_EB_EN     = 2;
	localparam int CTRL_PEAK      = 3;
	localparam int CTRL_RED_LSB   = 4;
	localparam int CTRL_BLUE_LSB  = 6;
	localparam int CTRL_COLOR_LSB = 8;
	localparam int POS_W          = 2;
	localparam int LO_LSB         = 0;
	localparam int HI_LSB         = 16;
	localparam int HALF_W         = 16;
	localparam int STAT_DONE      = 0;
	localparam int STAT_CNT_LSB   = 16;
	localparam logic [DATA_W-1:0] CFG_RST = 32'h0000_0000;

	typedef enum logic [1:0]
	{
		COL_RED   = 2'h0,
		COL_GREEN = 2'h1,
		COL_BLUE  = 2'h3
	} isae_color_t;

endpackage

/* File: core/isae_top.sv */
/*
 * image statistics engine: focus engine and exposure balance engine
 * on one pixel stream, with an avalon-mm register and result slave.
 * assumes pixel sources on clk, eol and eof flagged with the last pixel.
 */
// Added by the designer: the register addresses and the Avalon-MM register port.
`timescale 1ns/100ps
// How it works
// - focus engine picks one colour component and filters it along each line
// - peak mode adds each line's largest focus value within a block
// - sum mode adds every focus value inside a block
// - focus grid counts are clamped to 36 across and 128 down
// - one programmed width and height serve every focus block
// - programmable 2x2 positions of red and blue, green elsewhere
// - separate horizontal starts for the block grid and the filtering
// - only every Nth line of a focus block contributes
// - two parallel dual-biquad filters, eleven coefficients each
// - exposure engine samples pixels and tests them against a limit
// - saturated samples are clipped to the limit and still summed
// - exposure grid counts are clamped to 36 across and 128 down
// - one programmed width and height serve every exposure window
// - one black row with its own vertical start and height
// - programmable horizontal and vertical sample spacing
// - focus and exposure geometry live in separate registers
// - pixel input comes from the capture port or memory readback
module isae_top
	import isae_pkg::*;
(
	input  wire logic                         clk,
	input  wire logic                         rst_n,
	input  wire logic                         ce,
	input  wire logic                         capValid,
	input  wire logic [isae_pkg::PIX_W-1:0]   capData,
	input  wire logic                         capEol,
	input  wire logic                         capEof,
	input  wire logic                         memValid,
	input  wire logic [isae_pkg::PIX_W-1:0]   memData,
	input  wire logic                         memEol,
	input  wire logic                         memEof,
	input  wire logic [isae_pkg::ADDR_W-1:0]  avs_address,
	input  wire logic                         avs_read,
	input  wire logic                         avs_write,
	input  wire logic [isae_pkg::DATA_W-1:0]  avs_writedata,
	output logic      [isae_pkg::DATA_W-1:0]  avs_readdata,
	output logic                              avs_waitrequest,
	output logic                              frameDone
);
	import isae_pkg::*;

	function automatic logic signed [ACC_W-1:0] mulc
	(
		input logic [COEF_W-1:0]        c,
		input logic signed [ACC_W-1:0]  v
	);
		logic signed [ACC_W+COEF_W-1:0] p;
		p = signed'(c) * v;
		return signed'(p[COEF_FRAC +: ACC_W]);
	endfunction

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [DATA_W-1:0]  cfg_reg [CFG_N];
	logic [COEF_W-1:0]  coef_reg [COEF_N];
	logic [DATA_W-1:0]  afMem [MEM_N];
	logic [DATA_W-1:0]  ebMem [MEM_N];
	logic [DATA_W-1:0]  blkMem [MAX_COLS];
	logic [DATA_W-1:0]  readData_reg;
	logic               waitReq_reg;
	logic               done_reg;
	logic [HALF_W-1:0]  frameCnt_reg;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	wire               busReq  = avs_read | avs_write;
	wire               wrFire  = avs_write & ~waitReq_reg;
	wire [WADDR_W-1:0] wAddr   = avs_address[ADDR_W-1:2];
	wire [WADDR_W-1:0] coefOff = wAddr - COEF_WBASE;
	wire [WADDR_W-1:0] afOff   = wAddr - AF_WBASE;
	wire [WADDR_W-1:0] ebOff   = wAddr - EB_WBASE;
	wire [WADDR_W-1:0] blkOff  = wAddr - BLK_WBASE;
	wire               isCfg   = wAddr < WADDR_W'(CFG_N);
	wire               isStat  = wAddr == WADDR_W'(CFG_STATUS);
	wire               isCoef  = (wAddr >= COEF_WBASE)
		&& (coefOff < WADDR_W'(COEF_N));
	wire               isAf    = (wAddr >= AF_WBASE)
		&& (afOff < WADDR_W'(MEM_N));
	wire               isEb    = (wAddr >= EB_WBASE)
		&& (ebOff < WADDR_W'(MEM_N));
	wire               isBlk   = (wAddr >= BLK_WBASE)
		&& (blkOff < WADDR_W'(MAX_COLS));
	wire [CFG_IW-1:0]  cfgSel  = wAddr[CFG_IW-1:0];
	wire [COEF_IW-1:0] coefSel = coefOff[COEF_IW-1:0];
	wire [DATA_W-1:0]  statWord = {frameCnt_reg,
		{(HALF_W-1){1'b0}}, done_reg};
	wire [DATA_W-1:0]  rdMux =
		isStat ? statWord :
		isCfg  ? cfg_reg[cfgSel] :
		isCoef ? DATA_W'(coef_reg[coefSel]) :
		isAf   ? afMem[afOff[IDX_W-1:0]] :
		isEb   ? ebMem[ebOff[IDX_W-1:0]] :
		isBlk  ? blkMem[blkOff[COL_W-1:0]] : CFG_RST;

	// ------------------------------------------------------------
	// configuration fields
	// ------------------------------------------------------------
	wire [DATA_W-1:0]  ctrl    = cfg_reg[CFG_CTRL];
	wire               afEn    = ctrl[CTRL_AF_EN];
	wire               ebEn    = ctrl[CTRL_EB_EN];
	wire               peak    = ctrl[CTRL_PEAK];
	wire [POS_W-1:0]   redPos  = ctrl[CTRL_RED_LSB +: POS_W];
	wire [POS_W-1:0]   bluePos = ctrl[CTRL_BLUE_LSB +: POS_W];
	wire [POS_W-1:0]   colSel  = ctrl[CTRL_COLOR_LSB +: POS_W];
	// each engine reads its own geometry words
	wire [HALF_W-1:0]  afHSt   = cfg_reg[CFG_AF_HST][LO_LSB +: HALF_W];
	wire [HALF_W-1:0]  afFSt   = cfg_reg[CFG_AF_HST][HI_LSB +: HALF_W];
	wire [HALF_W-1:0]  afVSt   = cfg_reg[CFG_AF_VST][LO_LSB +: HALF_W];
	wire [HALF_W-1:0]  afW     = cfg_reg[CFG_AF_SIZE][LO_LSB +: HALF_W];
	wire [HALF_W-1:0]  afH     = cfg_reg[CFG_AF_SIZE][HI_LSB +: HALF_W];
	wire [ROW_W-1:0]   afCntH  = cfg_reg[CFG_AF_COUNT][LO_LSB +: ROW_W];
	wire [ROW_W-1:0]   afCntV  = cfg_reg[CFG_AF_COUNT][HI_LSB +: ROW_W];
	wire [ROW_W-1:0]   afLinc  = cfg_reg[CFG_AF_LINC][LO_LSB +: ROW_W];
	wire [HALF_W-1:0]  ebHSt   = cfg_reg[CFG_EB_START][LO_LSB +: HALF_W];
	wire [HALF_W-1:0]  ebVSt   = cfg_reg[CFG_EB_START][HI_LSB +: HALF_W];
	wire [HALF_W-1:0]  ebW     = cfg_reg[CFG_EB_SIZE][LO_LSB +: HALF_W];
	wire [HALF_W-1:0]  ebH     = cfg_reg[CFG_EB_SIZE][HI_LSB +: HALF_W];
	wire [ROW_W-1:0]   ebCntH  = cfg_reg[CFG_EB_COUNT][LO_LSB +: ROW_W];
	wire [ROW_W-1:0]   ebCntV  = cfg_reg[CFG_EB_COUNT][HI_LSB +: ROW_W];
	wire [ROW_W-1:0]   ebHSp   = cfg_reg[CFG_EB_SAMP][LO_LSB +: ROW_W];
	wire [ROW_W-1:0]   ebVSp   = cfg_reg[CFG_EB_SAMP][HI_LSB +: ROW_W];
	wire [PIX_W-1:0]   satLim  = cfg_reg[CFG_EB_SAT][PIX_W-1:0];
	wire [HALF_W-1:0]  blkVSt  = cfg_reg[CFG_EB_BLACK][LO_LSB +: HALF_W];
	wire [HALF_W-1:0]  blkH    = cfg_reg[CFG_EB_BLACK][HI_LSB +: HALF_W];
	// grid counts clamped to the storage
	wire [ROW_W-1:0]   afColsE = (afCntH > ROW_W'(MAX_COLS))
		? ROW_W'(MAX_COLS) : afCntH;
	wire [ROW_W-1:0]   afRowsE = (afCntV > ROW_W'(MAX_ROWS))
		? ROW_W'(MAX_ROWS) : afCntV;
	wire [ROW_W-1:0]   ebColsE = (ebCntH > ROW_W'(MAX_COLS))
		? ROW_W'(MAX_COLS) : ebCntH;
	wire [ROW_W-1:0]   ebRowsE = (ebCntV > ROW_W'(MAX_ROWS))
		? ROW_W'(MAX_ROWS) : ebCntV;

	// ------------------------------------------------------------
	// pixel source and position
	// ------------------------------------------------------------
	// source selected by software
	wire               pixValid = ctrl[CTRL_SRC] ? memValid : capValid;
	wire [PIX_W-1:0]   pixData  = ctrl[CTRL_SRC] ? memData : capData;
	wire               pixEol   = ctrl[CTRL_SRC] ? memEol : capEol;
	wire               pixEof   = ctrl[CTRL_SRC] ? memEof : capEof;
	wire               lineDone = pixValid & (pixEol | pixEof);

	logic [COORD_W-1:0] x_reg, y_reg;
	logic [COL_W-1:0]   afCol_reg, ebCol_reg;
	logic [HALF_W-1:0]  afCnt_reg, ebCnt_reg, afRowCnt_reg, ebRowCnt_reg;
	logic [ROW_W-1:0]   afRow_reg, ebRow_reg, afLSel_reg;
	logic [ROW_W-1:0]   ebHS_reg, ebVS_reg, blkVS_reg;
	logic [FV_W-1:0]    lineMax_reg;
	logic [DATA_W-1:0]  afAcc [MAX_COLS];
	logic [DATA_W-1:0]  ebAcc [MAX_COLS];
	logic [DATA_W-1:0]  blkAcc [MAX_COLS];

	// colour of the current 2x2 cell position
	wire [POS_W-1:0]   cellPos = {y_reg[0], x_reg[0]};
	wire [POS_W-1:0]   pixCol  = (cellPos == redPos) ? COL_RED :
		(cellPos == bluePos) ? COL_BLUE : COL_GREEN;

	// ------------------------------------------------------------
	// focus filters
	// ------------------------------------------------------------
	// only the chosen colour, from the filter start on
	wire filtStep = pixValid & afEn & (pixCol == colSel)
		& (x_reg >= afFSt);
	wire signed [ACC_W-1:0] pixS = signed'(ACC_W'(pixData));
	wire signed [ACC_W-1:0] filtOut [FILT_N];

	for (genvar f = 0; f < FILT_N; f++)
	begin : gFilt
		logic signed [ACC_W-1:0] x1_reg, x2_reg, y1_reg, y2_reg;
		logic signed [ACC_W-1:0] w1_reg, w2_reg;
		wire signed [ACC_W-1:0] inG = mulc(coef_reg[f*COEF_PER], pixS);
		wire signed [ACC_W-1:0] st1 = mulc(coef_reg[f*COEF_PER+1], inG)
			+ mulc(coef_reg[f*COEF_PER+2], x1_reg)
			+ mulc(coef_reg[f*COEF_PER+3], x2_reg)
			- mulc(coef_reg[f*COEF_PER+4], y1_reg)
			- mulc(coef_reg[f*COEF_PER+5], y2_reg);
		wire signed [ACC_W-1:0] st2 = mulc(coef_reg[f*COEF_PER+6], st1)
			+ mulc(coef_reg[f*COEF_PER+7], y1_reg)
			+ mulc(coef_reg[f*COEF_PER+8], y2_reg)
			- mulc(coef_reg[f*COEF_PER+9], w1_reg)
			- mulc(coef_reg[f*COEF_PER+10], w2_reg);
		assign filtOut[f] = st2;
		always_ff @(posedge clk)
		begin
			if (!rst_n || (ce && lineDone))
			begin
				x1_reg <= '0;
				x2_reg <= '0;
				y1_reg <= '0;
				y2_reg <= '0;
				w1_reg <= '0;
				w2_reg <= '0;
			end
			else if (ce && filtStep)
			begin
				x1_reg <= inG;
				x2_reg <= x1_reg;
				y1_reg <= st1;
				y2_reg <= y1_reg;
				w1_reg <= st2;
				w2_reg <= w1_reg;
			end
		end
	end

	wire [FV_W-1:0] abs0 = filtOut[0][ACC_W-1] ? FV_W'(-filtOut[0])
		: FV_W'(filtOut[0]);
	wire [FV_W-1:0] abs1 = filtOut[1][ACC_W-1] ? FV_W'(-filtOut[1])
		: FV_W'(filtOut[1]);
	wire [FV_W-1:0] fv   = abs0 + abs1;

	// ------------------------------------------------------------
	// focus block tracking and accumulation
	// ------------------------------------------------------------
	// one block size, nothing outside the grid
	wire afInH    = (x_reg >= afHSt) && (ROW_W'(afCol_reg) < afColsE);
	wire afInV    = (y_reg >= afVSt) && (afRow_reg < afRowsE);
	wire afColEnd = afInH && (afCnt_reg == afW - HALF_W'(1));
	wire afLast   = afRowCnt_reg == afH - HALF_W'(1);
	wire afStep   = pixValid && afEn && afInH && afInV;
	// line selected once every programmed increment
	wire afProc   = afLSel_reg == ROW_W'(0);
	wire afWr     = afStep && afColEnd && afLast;
	wire [FV_W-1:0] peakNow = (filtStep && fv > lineMax_reg)
		? fv : lineMax_reg;
	// peak adds the line maximum, sum adds every value
	wire [FV_W-1:0] afAdd = !afProc ? FV_W'(0) :
		peak ? (afColEnd ? peakNow : FV_W'(0)) :
		(filtStep ? fv : FV_W'(0));
	wire [DATA_W-1:0] afSum = afAcc[afCol_reg] + DATA_W'(afAdd);
	wire [IDX_W-1:0]  afIdx = IDX_W'(afRow_reg) * IDX_W'(MAX_COLS)
		+ IDX_W'(afCol_reg);

	// ------------------------------------------------------------
	// exposure balance window tracking and accumulation
	// ------------------------------------------------------------
	wire ebInH    = (x_reg >= ebHSt) && (ROW_W'(ebCol_reg) < ebColsE);
	wire ebInV    = (y_reg >= ebVSt) && (ebRow_reg < ebRowsE);
	wire ebColEnd = ebInH && (ebCnt_reg == ebW - HALF_W'(1));
	wire ebLast   = ebRowCnt_reg == ebH - HALF_W'(1);
	// black row placed by its own start and height
	wire blkIn    = (y_reg >= blkVSt) && (y_reg < blkVSt + blkH);
	wire blkLast  = y_reg == blkVSt + blkH - HALF_W'(1);
	wire ebHit    = pixValid && ebEn && ebInH && (ebHS_reg == ROW_W'(0));
	// saturated samples clipped to the limit
	wire [PIX_W-1:0]  ebVal  = (pixData > satLim) ? satLim : pixData;
	wire ebStep   = pixValid && ebEn && ebInH && ebInV;
	wire blkStep  = pixValid && ebEn && ebInH && blkIn;
	wire ebWr     = ebStep && ebColEnd && ebLast;
	wire blkWr    = blkStep && ebColEnd && blkLast;
	wire [DATA_W-1:0] ebSum = ebAcc[ebCol_reg]
		+ ((ebHit && ebVS_reg == ROW_W'(0)) ? DATA_W'(ebVal) : CFG_RST);
	wire [DATA_W-1:0] blkSum = blkAcc[ebCol_reg]
		+ ((ebHit && blkVS_reg == ROW_W'(0)) ? DATA_W'(ebVal) : CFG_RST);
	wire [IDX_W-1:0]  ebIdx = IDX_W'(ebRow_reg) * IDX_W'(MAX_COLS)
		+ IDX_W'(ebCol_reg);

	// ------------------------------------------------------------
	// counters along a line
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n || (ce && lineDone))
		begin
			x_reg       <= '0;
			afCol_reg   <= '0;
			afCnt_reg   <= '0;
			ebCol_reg   <= '0;
			ebCnt_reg   <= '0;
			ebHS_reg    <= '0;
			lineMax_reg <= '0;
		end
		else if (ce && pixValid)
		begin
			x_reg <= x_reg + COORD_W'(1);
			if (afInH)
			begin
				afCnt_reg <= afColEnd ? '0 : afCnt_reg + HALF_W'(1);
				afCol_reg <= afColEnd ? afCol_reg + COL_W'(1) : afCol_reg;
			end
			if (afStep)
				lineMax_reg <= (afColEnd || !afProc) ? '0 : peakNow;
			if (ebInH)
			begin
				ebCnt_reg <= ebColEnd ? '0 : ebCnt_reg + HALF_W'(1);
				ebCol_reg <= ebColEnd ? ebCol_reg + COL_W'(1) : ebCol_reg;
				ebHS_reg  <= (ebColEnd || ebHS_reg + ROW_W'(1) >= ebHSp)
					? '0 : ebHS_reg + ROW_W'(1);
			end
		end
	end

	// ------------------------------------------------------------
	// counters down a frame
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n || (ce && pixValid && pixEof))
		begin
			y_reg        <= '0;
			afRow_reg    <= '0;
			afRowCnt_reg <= '0;
			afLSel_reg   <= '0;
			ebRow_reg    <= '0;
			ebRowCnt_reg <= '0;
			ebVS_reg     <= '0;
			blkVS_reg    <= '0;
		end
		else if (ce && pixValid && pixEol)
		begin
			y_reg <= y_reg + COORD_W'(1);
			if (afInV)
			begin
				afRowCnt_reg <= afLast ? '0 : afRowCnt_reg + HALF_W'(1);
				afRow_reg    <= afLast ? afRow_reg + ROW_W'(1) : afRow_reg;
				afLSel_reg   <= (afLast || afLSel_reg + ROW_W'(1) >= afLinc)
					? '0 : afLSel_reg + ROW_W'(1);
			end
			if (ebInV)
			begin
				ebRowCnt_reg <= ebLast ? '0 : ebRowCnt_reg + HALF_W'(1);
				ebRow_reg    <= ebLast ? ebRow_reg + ROW_W'(1) : ebRow_reg;
				ebVS_reg     <= (ebLast || ebVS_reg + ROW_W'(1) >= ebVSp)
					? '0 : ebVS_reg + ROW_W'(1);
			end
			if (blkIn)
				blkVS_reg <= (blkLast || blkVS_reg + ROW_W'(1) >= ebVSp)
					? '0 : blkVS_reg + ROW_W'(1);
		end
	end

	// ------------------------------------------------------------
	// accumulators and result storage
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < MAX_COLS; i++)
			begin
				afAcc[i]  <= '0;
				ebAcc[i]  <= '0;
				blkAcc[i] <= '0;
			end
		end
		else if (ce)
		begin
			if (afStep)
				afAcc[afCol_reg] <= afWr ? '0 : afSum;
			if (ebStep)
				ebAcc[ebCol_reg] <= ebWr ? '0 : ebSum;
			if (blkStep)
				blkAcc[ebCol_reg] <= blkWr ? '0 : blkSum;
		end
	end

	// finished block results go to result storage
	always_ff @(posedge clk)
	begin
		if (ce && afWr)
			afMem[afIdx] <= afSum;
		if (ce && ebWr)
			ebMem[ebIdx] <= ebSum;
		if (ce && blkWr)
			blkMem[ebCol_reg] <= blkSum;
	end

	// ------------------------------------------------------------
	// register slave and status
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < CFG_N; i++)
				cfg_reg[i] <= CFG_RST;
			for (int i = 0; i < COEF_N; i++)
				coef_reg[i] <= '0;
			waitReq_reg  <= 1'b1;
			readData_reg <= '0;
			done_reg     <= 1'b0;
			frameCnt_reg <= '0;
		end
		else if (ce)
		begin
			waitReq_reg <= ~(busReq & waitReq_reg);
			if (busReq & waitReq_reg)
				readData_reg <= avs_read ? rdMux : CFG_RST;
			if (wrFire && isCfg && !isStat)
				cfg_reg[cfgSel] <= avs_writedata;
			if (wrFire && isCoef)
				coef_reg[coefSel] <= avs_writedata[COEF_W-1:0];
			// frame end sets the flag ahead of a clear
			if (pixValid && pixEof)
				done_reg <= 1'b1;
			else if (wrFire && isStat && avs_writedata[STAT_DONE])
				done_reg <= 1'b0;
			if (pixValid && pixEof)
				frameCnt_reg <= frameCnt_reg + HALF_W'(1);
		end
	end

	assign avs_readdata    = readData_reg;
	assign avs_waitrequest = waitReq_reg;
	assign frameDone       = done_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	AST_DONE_SET: assert property (@(posedge clk) disable iff (!rst_n)
		ce && pixValid && pixEof |=> done_reg)
		else $error("frame end did not set done");
	AST_OUTSIDE: assert property (@(posedge clk) disable iff (!rst_n)
		!(afInH && afInV) |-> !afWr && !afStep)
		else $error("focus write outside grid");
	AST_CLIP: assert property (@(posedge clk) disable iff (!rst_n)
		ebHit |-> ebVal <= satLim)
		else $error("sample above limit");
	AST_SAT: assert property (@(posedge clk) disable iff (!rst_n)
		ebHit && pixData > satLim |-> ebVal == satLim)
		else $error("saturated sample not clipped");
	AST_PEAK: assert property (@(posedge clk) disable iff (!rst_n)
		peak && afProc && afColEnd |-> afAdd >= lineMax_reg)
		else $error("peak below line maximum");
	AST_SUM: assert property (@(posedge clk) disable iff (!rst_n)
		!peak && afProc && filtStep |-> afAdd == fv)
		else $error("sum mode lost a value");
	AST_GRID: assert property (@(posedge clk) disable iff (!rst_n)
		afStep |-> afCol_reg < COL_W'(MAX_COLS) && afRow_reg < afRowsE)
		else $error("focus block out of grid");
	AST_EB_ROWS: assert property (@(posedge clk) disable iff (!rst_n)
		ebWr |-> ebRow_reg < ROW_W'(MAX_ROWS) && ebRowsE <= ROW_W'(MAX_ROWS))
		else $error("window row out of grid");
	AST_SRC: assert property (@(posedge clk) disable iff (!rst_n)
		ctrl[CTRL_SRC] |-> pixData == memData && pixValid == memValid)
		else $error("wrong pixel source");

endmodule // isae_top

/* File: sim/isae_pix_src.sv */
/*
 * pixel source model: one frame of constant pixels on either port.
 * assumes the engine samples on the rising edge of clk.
 */
`timescale 1ns/100ps
module isae_pix_src
	import isae_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               start,
	input  wire logic               useMem,
	input  wire logic               gappy,
	input  wire logic [7:0]         width,
	input  wire logic [7:0]         height,
	input  wire logic [PIX_W-1:0]   pixVal,
	output logic                    capValid,
	output logic      [PIX_W-1:0]   capData,
	output logic                    capEol,
	output logic                    capEof,
	output logic                    memValid,
	output logic      [PIX_W-1:0]   memData,
	output logic                    memEol,
	output logic                    memEof,
	output logic                    busy
);
	logic             run = 1'b0;
	logic             ph = 1'b0;
	logic             vld = 1'b0;
	logic             eol = 1'b0;
	logic             eof = 1'b0;
	logic [PIX_W-1:0] dat = '0;
	logic [7:0]       x = 8'h00;
	logic [7:0]       y = 8'h00;
	logic             lastX;
	logic             emit;
	assign lastX = x == width - 8'h01;
	// a slow source idles every other cycle
	assign emit = run && !(gappy && ph);
	assign busy = run;
	// idle data lines toggle so stale values are never trusted
	assign capValid = vld && !useMem;
	assign capData = useMem ? ~dat : dat;
	assign capEol = eol && !useMem;
	assign capEof = eof && !useMem;
	assign memValid = vld && useMem;
	assign memData = useMem ? dat : ~dat;
	assign memEol = eol && useMem;
	assign memEof = eof && useMem;
	always @(posedge clk)
	begin
		ph <= run ? ~ph : 1'b0;
		vld <= emit;
		dat <= emit ? pixVal : ~dat;
		eol <= emit && lastX;
		eof <= emit && lastX && y == height - 8'h01;
		if (start && !run)
		begin
			run <= 1'b1;
			x <= 8'h00;
			y <= 8'h00;
		end
		else if (emit)
		begin
			x <= lastX ? 8'h00 : x + 8'h01;
			y <= lastX ? y + 8'h01 : y;
			run <= !(lastX && y == height - 8'h01);
		end
	end
endmodule // isae_pix_src

/* File: sim/tb.sv */
/*
 * testbench: register bus tasks and exposure and focus engine frame scenarios.
 * assumes the pixel source model and the engine share clk.
 */
`timescale 1ns/100ps
module tb;
	import isae_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, start = 1'b0;
	logic useMem = 1'b0, gappy = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic capValid, capEol, capEof, memValid, memEol, memEof, busy;
	logic avs_waitrequest, frameDone;
	logic [PIX_W-1:0]  capData, memData, pixVal = 14'h0032;
	logic [ADDR_W-1:0] avs_address = 17'h00000;
	logic [DATA_W-1:0] avs_writedata = 32'h0, avs_readdata;
	int miscompares = 0, total_checks = 0;
	always #25 clk = ~clk;
	isae_pix_src u_src(.clk(clk), .start(start), .useMem(useMem),
		.gappy(gappy), .width(8'h0A), .height(8'h06), .pixVal(pixVal),
		.capValid(capValid), .capData(capData), .capEol(capEol),
		.capEof(capEof), .memValid(memValid), .memData(memData),
		.memEol(memEol), .memEof(memEof), .busy(busy));
	isae_top u_dut(.clk(clk), .rst_n(rst_n), .ce(ce), .capValid(capValid),
		.capData(capData), .capEol(capEol), .capEof(capEof),
		.memValid(memValid), .memData(memData), .memEol(memEol),
		.memEof(memEof), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.frameDone(frameDone));
	task report_and_stop;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task xfer(input logic wr, input logic [16:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 20)
		begin
			miscompares++;
			report_and_stop;
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask
	task wr(input logic [16:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task rd(input logic [16:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		check(q, e);
	endtask
	task run_frame;
		int n;
		n = 0;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		repeat (2) @(posedge clk);
		while (busy !== 1'b0 && n < 500)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 500)
		begin
			miscompares++;
			report_and_stop;
		end
		repeat (8) @(posedge clk);
	endtask
	initial
	begin
		#1000000;
		miscompares++;
		report_and_stop;
	end
	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(17'h00000, 32'h0);
		check({31'h0, frameDone}, 32'h0);
		rd(17'h00034, 32'h0);
		wr(17'h0001C, 32'h0001_0001);
		wr(17'h00020, 32'h0004_0004);
		wr(17'h00024, 32'h0001_0002);
		wr(17'h00028, 32'h0002_0002);
		wr(17'h0002C, 32'h0000_03E8);
		wr(17'h00030, 32'h0001_0005);
		wr(17'h00000, 32'h0000_0004);
		run_frame;
		check({31'h0, frameDone}, 32'h1);
		rd(17'h10000, 32'h0000_00C8);
		rd(17'h10004, 32'h0000_00C8);
		rd(17'h18000, 32'h0000_0064);
		wr(17'h10000, 32'h0000_FFFF);
		rd(17'h10000, 32'h0000_00C8);
		wr(17'h00004, 32'h0000_0001);
		@(posedge clk);
		check({31'h0, frameDone}, 32'h0);
		useMem <= 1'b1;
		gappy <= 1'b1;
		pixVal <= 14'h012C;
		wr(17'h00028, 32'h0001_0001);
		wr(17'h0002C, 32'h0000_0064);
		// focus: filter 0 passes the pixel through, filter 1 silent
		wr(17'h00040, 32'h0000_0040);
		wr(17'h00044, 32'h0000_0040);
		wr(17'h00058, 32'h0000_0040);
		wr(17'h00010, 32'h0002_0002);
		wr(17'h00014, 32'h0001_0002);
		// mem source, both engines, sum mode, blue at 3, green chosen
		wr(17'h00000, 32'h0000_01C7);
		run_frame;
		rd(17'h10000, 32'h0000_0640);
		rd(17'h10004, 32'h0000_0640);
		rd(17'h08000, 32'h0000_0258);
		rd(17'h08004, 32'h0000_0258);
		// peak mode, every second line
		wr(17'h00018, 32'h0000_0002);
		wr(17'h00000, 32'h0000_01CF);
		run_frame;
		rd(17'h08000, 32'h0000_012C);
		rd(17'h08004, 32'h0000_012C);
		report_and_stop;
	end
endmodule // tb
